// >>> verilog/cpu_regs_defs.svh
// constants for the cpu status and flag register block
`ifndef CPU_REGS_DEFS_SVH
`define CPU_REGS_DEFS_SVH
// apb byte addresses
`define ADDR_GPR_BASE 12'h000
`define ADDR_STATUS 12'h040
`define ADDR_FLAGS 12'h044
`define ADDR_IRQ_OUT 12'h048
`define ADDR_PTRS 12'h04c
`define ADDR_PROG_PTR 12'h050
// status register fields
`define ST_L2_EN 7
`define ST_L1_EN 6
`define ST_GLOBAL_EN 5
`define ST_L2_PEND 4
`define ST_L1_PEND 3
`define ST_L0_PEND 2
`define ST_EV_LOW 1
`define ST_EV_HIGH 0
`define STATUS_RESET 8'h00
// flag register fields
`define FL_ZERO 2
`define FL_CARRY 1
`define FL_OVF 0
`define FLAGS_RESET 3'h0
// register index of special registers in the file
`define IDX_ACC 4'hf
`define IDX_STATUS 4'he
`define IDX_PTR_BASE 4'h4
`define IDX_PROG_HI 4'hc
`define IDX_PROG_LO 4'hd
`endif

// >>> verilog/cpu_regs_pkg.sv
// types for the cpu status and flag register block
package cpu_regs_pkg;
  typedef enum logic [2:0] {
    ALU_NONE = 3'h0,
    ALU_SHL = 3'h1,
    ALU_SHR = 3'h2,
    ALU_ADD = 3'h3,
    ALU_SUB = 3'h4,
    ALU_LOGIC = 3'h5
  } alu_op_t;
  typedef enum logic [2:0] {
    APB_IDLE = 3'b001,
    APB_ACCESS = 3'b010,
    APB_DONE = 3'b100
  } apb_state_t;
endpackage

// >>> verilog/reg_bank.sv
// sixteen-entry byte register file with registered read port
`timescale 1ns/1ps
module reg_bank #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // write port
  input wire logic writeEn,
  input wire logic [$clog2(DEPTH)-1:0] writeIdx,
  input wire logic [WIDTH-1:0] writeData,
  // read port
  input wire logic [$clog2(DEPTH)-1:0] readIdx,
  output logic [WIDTH-1:0] readData,
  // all entries for pointer formation
  output logic [DEPTH*WIDTH-1:0] allData
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [WIDTH-1:0] next_readData;

  always_comb begin
    next_mem = mem;
    if (writeEn) begin
      next_mem[writeIdx] = writeData;
    end
    next_readData = mem[readIdx];
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      readData <= '0;
    end else begin
      mem <= next_mem;
      readData <= next_readData;
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gFlat
      assign allData[g*WIDTH +: WIDTH] = mem[g];
    end
  endgenerate
endmodule

// >>> verilog/flag_unit.sv
// condition flag update for shift and arithmetic results
`timescale 1ns/1ps
module flag_unit (
  // operation
  input wire cpu_regs_pkg::alu_op_t op,
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic carryIn,
  input wire logic [7:0] accValue,
  // flags
  output logic [7:0] result,
  output logic carryOut,
  output logic ovfOut,
  output logic carryWrite,
  output logic zeroOut
);
  import cpu_regs_pkg::*;
  logic [8:0] wide;

  assign zeroOut = (accValue == 8'h00);

  always_comb begin
    wide = 9'h000;
    result = opA;
    carryOut = carryIn;
    ovfOut = 1'b0;
    carryWrite = 1'b0;
    unique case (op)
      ALU_SHL: begin
        result = {opA[6:0], 1'b0};
        carryOut = opA[7];
        ovfOut = opA[7] ^ opA[6];
        carryWrite = 1'b1;
      end
      ALU_SHR: begin
        result = {1'b0, opA[7:1]};
        carryOut = opA[0];
        ovfOut = opA[7];
        carryWrite = 1'b1;
      end
      ALU_ADD: begin
        wide = {1'b0, opA} + {1'b0, opB};
        result = wide[7:0];
        carryOut = wide[8];
        ovfOut = (opA[7] == opB[7]) && (result[7] != opA[7]);
        carryWrite = 1'b1;
      end
      ALU_SUB: begin
        wide = {1'b0, opA} - {1'b0, opB};
        result = wide[7:0];
        carryOut = ~wide[8];
        ovfOut = (opA[7] != opB[7]) && (result[7] != opA[7]);
        carryWrite = 1'b1;
      end
      ALU_LOGIC: begin
        result = opA & opB;
      end
      ALU_NONE: begin
        result = opA;
      end
      default: begin
        result = opA;
      end
    endcase
  end
endmodule

// >>> verilog/cpu_status_and_flag_regs.sv
// programmer-visible cpu registers, status register and condition flags
// Overview of operation
// - level-two request reaches core only while level-two enable is set
// - level-one request reaches core only while level-one enable is set
// - global enable gates every interrupt level; zero blocks all
// - low-priority handler sources set level-two pending bit
// - medium-priority handler sources set level-one pending bit
// - high-priority handler sources set level-zero pending bit
// - low-priority event sources set low event pending bit
// - high-priority event sources set high event pending bit
// - zero flag is one exactly when accumulator equals zero; the code updates it one cycle after the accumulator
// - shifts load carry with the bit shifted out
// - unsigned addition overflow sets carry to one
// - unsigned subtraction underflow clears carry, an active-low borrow
// - signed overflow or underflow sets the overflow flag
// - four data index pointers concatenate high and low bytes
// - program index pointer concatenates its high and low bytes
// - sixteen byte registers, pairs usable as sixteen-bit words
// - after halt an event resumes in line, interrupt branches to routine
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "cpu_regs_defs.svh"
module cpu_status_and_flag_regs #(
  parameter int NUM_REGS = 16,
  parameter int NUM_PTRS = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt and event handler requests
  input wire logic irqLow,
  input wire logic irqMid,
  input wire logic irqHigh,
  input wire logic evLow,
  input wire logic evHigh,
  // core datapath update
  input wire cpu_regs_pkg::alu_op_t aluOp,
  input wire logic [3:0] destIdx,
  input wire logic [7:0] srcValue,
  input wire logic [7:0] operandB,
  input wire logic halted,
  // requests to the core
  output logic takeIrqL2,
  output logic takeIrqL1,
  output logic takeIrqL0,
  output logic resumeFromHalt,
  output logic branchToIsr,
  // pointers
  output logic [NUM_PTRS*16-1:0] dataPointers,
  output logic [15:0] programPointer
);
  import cpu_regs_pkg::*;

  apb_state_t state, next_state;
  logic [7:0] status, next_status;
  logic [2:0] flags, next_flags;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [7:0] fuResult;
  logic fuCarry, fuOvf, fuCarryWrite, fuZero;
  logic [NUM_REGS*8-1:0] allRegs;
  logic bankWe;
  logic [3:0] bankWIdx;
  logic [7:0] bankWData;
  logic [3:0] bankRIdx;
  logic [7:0] bankRData;
  logic [7:0] accValue;
  logic swWrite, swRead, regHit, regWin;
  logic [3:0] swIdx;
  logic l2Go, l1Go, l0Go;
  logic hitStatus, hitFlags, hitIrqOut, hitPtrs, hitProgPtr, hitAny, misaligned;
  logic [31:0] readMux;

  assign accValue = allRegs[`IDX_ACC*8 +: 8];

  // datapath writes the destination register; apb writes win only if no alu op
  assign regWin = (aluOp != ALU_NONE);
  assign regHit = (paddr < `ADDR_STATUS) && (paddr[1:0] == 2'b00);
  assign swIdx = paddr[5:2];
  assign swWrite = (state == APB_ACCESS) && pwrite;
  assign swRead = (state == APB_ACCESS) && !pwrite;

  // one decode per mapped word; the byte registers sit below the status word
  assign hitStatus = (paddr == `ADDR_STATUS);
  assign hitFlags = (paddr == `ADDR_FLAGS);
  assign hitIrqOut = (paddr == `ADDR_IRQ_OUT);
  assign hitPtrs = (paddr == `ADDR_PTRS);
  assign hitProgPtr = (paddr == `ADDR_PROG_PTR);
  assign misaligned = (paddr[1:0] != 2'b00);
  assign hitAny = regHit || hitStatus || hitFlags || hitIrqOut || hitPtrs || hitProgPtr;

  flag_unit uFlags (
    .op(aluOp),
    .opA(srcValue),
    .opB(operandB),
    .carryIn(flags[`FL_CARRY]),
    .accValue(accValue),
    .result(fuResult),
    .carryOut(fuCarry),
    .ovfOut(fuOvf),
    .carryWrite(fuCarryWrite),
    .zeroOut(fuZero)
  );

  always_comb begin
    bankWe = 1'b0;
    bankWIdx = destIdx;
    bankWData = fuResult;
    if (regWin) begin
      bankWe = 1'b1;
    end else if (swWrite && regHit && swIdx != `IDX_STATUS) begin
      bankWe = 1'b1;
      bankWIdx = swIdx;
      bankWData = pwdata[7:0];
    end
    // the bank is read from paddr every cycle, so a read sees its word in the access cycle
    bankRIdx = swIdx;
  end

  reg_bank #(
    .DEPTH(NUM_REGS),
    .WIDTH(8)
  ) uBank (
    .clock(clock),
    .sys_rst(sys_rst),
    .writeEn(bankWe),
    .writeIdx(bankWIdx),
    .writeData(bankWData),
    .readIdx(bankRIdx),
    .readData(bankRData),
    .allData(allRegs)
  );

  genvar p;
  generate
    for (p = 0; p < NUM_PTRS; p++) begin : gPtr
      assign dataPointers[p*16 +: 16] = {allRegs[(`IDX_PTR_BASE + 2*p)*8 +: 8],
                                         allRegs[(`IDX_PTR_BASE + 2*p + 1)*8 +: 8]};
    end
  endgenerate

  assign programPointer = {allRegs[`IDX_PROG_HI*8 +: 8], allRegs[`IDX_PROG_LO*8 +: 8]};

  // interrupt gating toward the core; level zero has no enable of its own
  assign l2Go = status[`ST_GLOBAL_EN] && status[`ST_L2_EN] && status[`ST_L2_PEND];
  assign l1Go = status[`ST_GLOBAL_EN] && status[`ST_L1_EN] && status[`ST_L1_PEND];
  assign l0Go = status[`ST_GLOBAL_EN] && status[`ST_L0_PEND];
  // lowest level number wins when several levels are pending
  always_comb begin
    takeIrqL0 = 1'b0;
    takeIrqL1 = 1'b0;
    takeIrqL2 = 1'b0;
    if (l0Go) begin
      takeIrqL0 = 1'b1;
    end else if (l1Go) begin
      takeIrqL1 = 1'b1;
    end else if (l2Go) begin
      takeIrqL2 = 1'b1;
    end
  end
  // an interrupt wins over an event when both wake a halted core
  assign branchToIsr = halted && (l0Go || l1Go || l2Go);
  assign resumeFromHalt = halted && !branchToIsr
                          && (status[`ST_EV_LOW] || status[`ST_EV_HIGH]);

  // status register: software write, then hardware set wins
  always_comb begin
    next_status = status;
    if (swWrite && hitStatus) begin
      next_status = pwdata[7:0];
    end else if (regWin && destIdx == `IDX_STATUS) begin
      next_status = fuResult;
    end
    // a request arriving with a software clear must survive it
    if (irqLow) begin
      next_status[`ST_L2_PEND] = 1'b1;
    end
    if (irqMid) begin
      next_status[`ST_L1_PEND] = 1'b1;
    end
    if (irqHigh) begin
      next_status[`ST_L0_PEND] = 1'b1;
    end
    if (evLow) begin
      next_status[`ST_EV_LOW] = 1'b1;
    end
    if (evHigh) begin
      next_status[`ST_EV_HIGH] = 1'b1;
    end
  end

  // condition flags
  always_comb begin
    next_flags = flags;
    if (swWrite && paddr == `ADDR_FLAGS) begin
      next_flags[`FL_CARRY] = pwdata[`FL_CARRY];
      next_flags[`FL_OVF] = pwdata[`FL_OVF];
    end
    if (fuCarryWrite) begin
      next_flags[`FL_CARRY] = fuCarry;
      next_flags[`FL_OVF] = fuOvf;
    end
    // zero follows the accumulator one cycle late
    next_flags[`FL_ZERO] = fuZero;
  end

  // read data for the addressed word, registered at the first access edge
  always_comb begin
    readMux = 32'h00000000;
    if (regHit) begin
      if (swIdx == `IDX_STATUS) begin
        readMux = {24'h000000, status};
      end else begin
        readMux = {24'h000000, bankRData};
      end
    end else if (hitStatus) begin
      readMux = {24'h000000, status};
    end else if (hitFlags) begin
      readMux = {29'h00000000, flags};
    end else if (hitIrqOut) begin
      readMux = {27'h0000000, branchToIsr, resumeFromHalt, takeIrqL2, takeIrqL1, takeIrqL0};
    end else if (hitPtrs) begin
      readMux = dataPointers[31:0];
    end else if (hitProgPtr) begin
      readMux = {16'h0000, programPointer};
    end
  end

  // apb slave: setup, one access cycle, then ready in the completion cycle
  always_comb begin
    next_state = state;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    unique case (state)
      APB_IDLE: begin
        if (psel && !penable) begin
          next_state = APB_ACCESS;
        end
      end
      APB_ACCESS: begin
        next_state = APB_DONE;
        if (swRead) begin
          next_prdata = readMux;
        end
        next_pslverr = !hitAny || misaligned;
      end
      APB_DONE: begin
        // a setup right after completion is taken back to back
        if (psel && !penable) begin
          next_state = APB_ACCESS;
        end else begin
          next_state = APB_IDLE;
        end
      end
      default: begin
        next_state = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= APB_IDLE;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      state <= next_state;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status <= `STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flags <= `FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // ready in the completion cycle, while prdata and pslverr stand
  assign pready = (state == APB_DONE) && psel && penable;
endmodule

// >>> test/cpu_status_and_flag_regs_asserts.sv
// assertion checker for the cpu status and flag register block
`timescale 1ns/1ps
module cpu_status_and_flag_regs_asserts
  import cpu_regs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // requests and datapath
  input wire logic irqLow,
  input wire logic irqHigh,
  input wire cpu_regs_pkg::alu_op_t aluOp,
  input wire logic halted,
  input wire logic takeIrqL2,
  input wire logic takeIrqL1,
  input wire logic takeIrqL0,
  input wire logic resumeFromHalt,
  input wire logic branchToIsr
);
  import cpu_regs_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // software or datapath may rewrite the status register this cycle
  logic sw;
  assign sw = (psel && pwrite) || (aluOp != ALU_NONE);
  a_reset_clear: assert property (disable iff (1'b0) sys_rst |=> !takeIrqL0 && !takeIrqL1 && !takeIrqL2
    && !pslverr && prdata == 32'h0) else $error("outputs not cleared by reset");
  a_l0_first: assert property (takeIrqL0 |-> !takeIrqL1 && !takeIrqL2)
    else $error("level zero not exclusive");
  a_l0_cause: assert property ($rose(takeIrqL0) |-> $past(irqHigh) || $past(sw))
    else $error("level zero request without cause");
  a_l2_cause: assert property ($rose(takeIrqL2) |-> $past(irqLow) || $past(sw))
    else $error("level two request without cause");
  a_pend_hold: assert property (takeIrqL0 && !sw |=> takeIrqL0)
    else $error("pending request dropped by hardware");
  a_ready_wait: assert property (psel && !penable |=> !pready)
    else $error("no wait state");
  a_ready_bound: assert property (psel && penable && !pready |=> pready)
    else $error("answer late");
  a_misalign_err: assert property (psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  a_halt_wake: assert property (resumeFromHalt || branchToIsr |-> halted)
    else $error("wake while running");
  c_l0: cover property (takeIrqL0);
  c_resume: cover property (resumeFromHalt);
  c_err: cover property (pready && pslverr);
endmodule

// >>> test/irq_event_source.sv
// behavioural interrupt and event handler pulsing its request lines
`timescale 1ns/1ps
module irq_event_source (
  // clock
  input wire logic clock,
  // selection {irqLow, irqMid, irqHigh, evLow, evHigh}
  input wire logic [4:0] fire,
  // request lines
  output logic irqLow,
  output logic irqMid,
  output logic irqHigh,
  output logic evLow,
  output logic evHigh
);
  // each line follows its fire bit one clock later, so a one-cycle fire gives one pulse
  always_ff @(posedge clock) begin
    {irqLow, irqMid, irqHigh, evLow, evHigh} <= fire;
  end
endmodule

// >>> test/cpu_status_and_flag_regs_tb.sv
// self-checking bench for the cpu status and flag register block
`timescale 1ns/1ps
module cpu_status_and_flag_regs_tb;
  import cpu_regs_pkg::*;
  logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, halted, err;
  logic irqLow, irqMid, irqHigh, evLow, evHigh, takeIrqL2, takeIrqL1, takeIrqL0, resumeFromHalt, branchToIsr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] destIdx;
  logic [7:0] srcValue, operandB;
  logic [4:0] fire;
  logic [63:0] dataPointers;
  logic [15:0] programPointer;
  alu_op_t aluOp;
  int numErrors, samplesChecked, cycles;
  cpu_status_and_flag_regs cpu_status_and_flag_regs_i (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irqLow, .irqMid, .irqHigh, .evLow, .evHigh, .aluOp, .destIdx,
    .srcValue, .operandB, .halted, .takeIrqL2, .takeIrqL1, .takeIrqL0, .resumeFromHalt, .branchToIsr,
    .dataPointers, .programPointer);
  irq_event_source irq_event_source_i (.clock, .fire, .irqLow, .irqMid, .irqHigh, .evLow, .evHigh);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic tallyAndFinish();
    $display("checks=%0d errors=%0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      numErrors++;
      tallyAndFinish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic alu(input alu_op_t op, input logic [7:0] a, input logic [7:0] b, input logic [7:0] res,
    input logic [2:0] fl);
    aluOp <= op;
    srcValue <= a;
    operandB <= b;
    @(posedge clock);
    aluOp <= ALU_NONE;
    @(posedge clock);
    rd(12'h03c, {24'h0, res});
    rd(12'h044, {29'h0, fl});
  endtask
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata, halted, fire} = {1'b1, 53'h0};
    {destIdx, srcValue, operandB, aluOp} = {4'hf, 16'h0, ALU_NONE};
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(12'h040, 32'h0);
    rd(12'h044, 32'h4);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 12'h040, 32'h0);
      fire <= 5'(1 << i);
      @(posedge clock);
      fire <= 5'h0;
      repeat (2) @(posedge clock);
      rd(12'h040, 32'(1 << i));
    end
    fire <= 5'h1f;
    @(posedge clock);
    fire <= 5'h0;
    repeat (2) @(posedge clock);
    rd(12'h048, 32'h0);
    apb(1'b1, 12'h040, 32'hdf);
    rd(12'h048, 32'h0);
    apb(1'b1, 12'h040, 32'hff);
    rd(12'h048, 32'h1);
    rd(12'h040, 32'hff);
    apb(1'b1, 12'h040, 32'hfb);
    rd(12'h048, 32'h2);
    apb(1'b1, 12'h040, 32'hb3);
    rd(12'h048, 32'h4);
    apb(1'b1, 12'h040, 32'h33);
    rd(12'h048, 32'h0);
    apb(1'b1, 12'h040, 32'h28);
    rd(12'h048, 32'h0);
    halted <= 1'b1;
    apb(1'b1, 12'h040, 32'h33);
    rd(12'h048, 32'h8);
    apb(1'b1, 12'h040, 32'hb0);
    rd(12'h048, 32'h14);
    halted <= 1'b0;
    apb(1'b1, 12'h040, 32'h0);
    rd(12'h040, 32'h0);
    alu(ALU_SUB, 8'h05, 8'h01, 8'h04, 3'h2);
    alu(ALU_SUB, 8'h00, 8'h01, 8'hff, 3'h0);
    alu(ALU_ADD, 8'h7f, 8'h01, 8'h80, 3'h1);
    alu(ALU_ADD, 8'hff, 8'h01, 8'h00, 3'h6);
    alu(ALU_SHL, 8'h80, 8'h00, 8'h00, 3'h7);
    alu(ALU_SHR, 8'h01, 8'h00, 8'h00, 3'h6);
    alu(ALU_SHR, 8'h82, 8'h00, 8'h41, 3'h1);
    alu(ALU_LOGIC, 8'hf0, 8'h3c, 8'h30, 3'h1);
    apb(1'b1, 12'h010, 32'h12);
    apb(1'b1, 12'h014, 32'h34);
    apb(1'b1, 12'h018, 32'h56);
    apb(1'b1, 12'h030, 32'hab);
    apb(1'b1, 12'h034, 32'hcd);
    apb(1'b1, 12'h020, 32'h9a);
    apb(1'b1, 12'h02c, 32'hef);
    rd(12'h04c, 32'h56001234);
    rd(12'h050, 32'habcd);
    chk({16'h0, programPointer}, 32'habcd);
    chk(dataPointers[63:32], 32'h00ef9a00);
    apb(1'b1, 12'h00c, 32'hffffff5a);
    rd(12'h00c, 32'h5a);
    rd(12'h060, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h041, 32'h0);
    chk({31'h0, err}, 32'h1);
    tallyAndFinish();
  end
endmodule
bind cpu_status_and_flag_regs cpu_status_and_flag_regs_asserts cpu_status_and_flag_regs_asserts_i (.clock,
  .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .irqLow, .irqHigh, .aluOp, .halted,
  .takeIrqL2, .takeIrqL1, .takeIrqL0, .resumeFromHalt, .branchToIsr);
